// ### hdl/lbc_regs.svh
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define LBC_IDX_PULSE_A      6'h14
`define LBC_IDX_PULSE_B      6'h15
`define LBC_IDX_PULSE_C      6'h16
`define LBC_IDX_PULSE_D      6'h17
`define LBC_IDX_PULSE_E      6'h18
`define LBC_IDX_PULSE_F      6'h19
`define LBC_IDX_AB_SETUP     6'h1A
`define LBC_IDX_C_SETUP      6'h1B
`define LBC_IDX_D_SETUP      6'h1C
`define LBC_IDX_E_SETUP      6'h1D
`define LBC_IDX_F_SETUP      6'h1E
`define LBC_IDX_MAX_A        6'h1F
`define LBC_IDX_MAX_B        6'h20
`define LBC_IDX_MAX_C        6'h21
`define LBC_IDX_MAX_D        6'h22
`define LBC_IDX_MAX_E        6'h23
`define LBC_IDX_MAX_F        6'h24
`define LBC_IDX_ANODE_TIE    6'h25
`define LBC_REG_COUNT        18

// ----------------------------------------------------------------
// Reset values and writable bit masks.
// ----------------------------------------------------------------
`define LBC_RST_PULSE        8'h38
`define LBC_RST_SETUP        8'h00
`define LBC_RST_MAX          8'h13
`define LBC_RST_ANODE        8'h7F
`define LBC_MASK_PULSE       8'h3F
`define LBC_MASK_AB_SETUP    8'h0F
`define LBC_MASK_LV_SETUP    8'h0F
`define LBC_MASK_MAX         8'h1F
`define LBC_MASK_ANODE       8'h7F

// ----------------------------------------------------------------
// Field positions and the full-scale current base and step.
// ----------------------------------------------------------------
`define LBC_PULSE_MASTER_BIT 0
`define LBC_PULSE_ZONE_LSB   1
`define LBC_AB_A_SOURCE_BIT  0
`define LBC_AB_A_LINEAR_BIT  1
`define LBC_AB_B_SOURCE_BIT  2
`define LBC_AB_B_LINEAR_BIT  3
`define LBC_LV_LINEAR_BIT    2
`define LBC_LV_PATTERN_BIT   3
`define LBC_FS_BASE_TENTH_MA 9'h032
`define LBC_FS_STEP_TENTH_MA 9'h008
`endif

// ### hdl/lbc_pkg.sv
package lbc_pkg;

  typedef enum logic [1:0] {
    LBC_SRC_BRIGHTNESS,
    LBC_SRC_MAP_ONE,
    LBC_SRC_MAP_TWO,
    LBC_SRC_MAP_THREE
  } lbc_src_t;

  typedef struct packed {
    logic       pwm_enable;
    logic [4:0] pwm_zone_enable;
    lbc_src_t   source;
    logic       zone_target_used;
    logic       linear_map;
    logic       pattern_enable;
    logic [4:0] full_scale_code;
    logic [8:0] full_scale_tenth_ma;
  } lbc_bank_cfg_t;

  typedef struct packed {
    logic [4:0] low_voltage_sink_tie;
    logic [1:0] high_voltage_string_tie;
  } lbc_anode_t;

endpackage : lbc_pkg

// ### hdl/lbc_cfg_reg.sv
`timescale 1ns/1ps
`include "lbc_regs.svh"

module lbc_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       write_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] value_out
);

  logic [7:0] value_reg;

  // Masked bits never store, so they always read back as zero.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      value_reg <= RESET_VALUE;
    end else if (write_in) begin
      value_reg <= data_in & WRITE_MASK;
    end
  end

  assign value_out = value_reg;

endmodule : lbc_cfg_reg

// ### hdl/lbc_bank_decode.sv
`timescale 1ns/1ps
`include "lbc_regs.svh"

module lbc_bank_decode #(
  parameter bit                LOW_VOLTAGE = 1'b1,
  parameter lbc_pkg::lbc_src_t HV_MAP      = lbc_pkg::LBC_SRC_MAP_ONE
) (
  input  wire logic [7:0]         pulse_in,
  input  wire logic [1:0]         select_in,
  input  wire logic               linear_in,
  input  wire logic               pattern_in,
  input  wire logic [7:0]         max_in,
  output lbc_pkg::lbc_bank_cfg_t  cfg_out
);

  lbc_pkg::lbc_src_t source;

  always_comb begin
    if (!LOW_VOLTAGE) begin
      source = select_in[0] ? HV_MAP : lbc_pkg::LBC_SRC_BRIGHTNESS;
    end else begin
      unique case (select_in)
        2'h0, 2'h1: source = lbc_pkg::LBC_SRC_BRIGHTNESS;
        2'h2:       source = lbc_pkg::LBC_SRC_MAP_TWO;
        2'h3:       source = lbc_pkg::LBC_SRC_MAP_THREE;
      endcase
    end
  end

  always_comb begin
    cfg_out                     = '0;
    cfg_out.pwm_enable          = pulse_in[`LBC_PULSE_MASTER_BIT];
    cfg_out.pwm_zone_enable     = pulse_in[`LBC_PULSE_ZONE_LSB +: 5];
    cfg_out.source              = source;
    cfg_out.linear_map          = linear_in;
    cfg_out.pattern_enable      = LOW_VOLTAGE && pattern_in;
    // A pattern would fight the zone targets, so the pattern wins.
    cfg_out.zone_target_used    = (source != lbc_pkg::LBC_SRC_BRIGHTNESS) &&
                                  !(LOW_VOLTAGE && pattern_in);
    cfg_out.full_scale_code     = max_in[4:0];
    cfg_out.full_scale_tenth_ma = `LBC_FS_BASE_TENTH_MA +
                                  9'(max_in[4:0]) * `LBC_FS_STEP_TENTH_MA;
  end

endmodule : lbc_bank_decode

// ### hdl/lbc_config_bank.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "lbc_regs.svh"

module lbc_config_bank (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [7:0]                    paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  input  wire logic [3:0]                    pstrb_in,
  output logic      [31:0]                   prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  output lbc_pkg::lbc_bank_cfg_t [5:0]       bank_cfg_out,
  output lbc_pkg::lbc_anode_t                anode_tie_out
);

  // ----------------------------------------------------------------
  // Slot layout
  // ----------------------------------------------------------------
  localparam int SLOT_AB    = 6;
  localparam int SLOT_LV    = 7;
  localparam int SLOT_MAX   = 11;
  localparam int SLOT_ANODE = 17;

  function automatic logic [7:0] reset_of(input int slot);
    logic [7:0] value;
    value = `LBC_RST_SETUP;
    if (slot < SLOT_AB) begin
      value = `LBC_RST_PULSE;
    end else if (slot >= SLOT_MAX && slot < SLOT_ANODE) begin
      value = `LBC_RST_MAX;
    end else if (slot == SLOT_ANODE) begin
      value = `LBC_RST_ANODE;
    end
    return value;
  endfunction : reset_of

  function automatic logic [7:0] mask_of(input int slot);
    logic [7:0] value;
    value = `LBC_MASK_LV_SETUP;
    if (slot < SLOT_AB) begin
      value = `LBC_MASK_PULSE;
    end else if (slot == SLOT_AB) begin
      value = `LBC_MASK_AB_SETUP;
    end else if (slot >= SLOT_MAX && slot < SLOT_ANODE) begin
      value = `LBC_MASK_MAX;
    end else if (slot == SLOT_ANODE) begin
      value = `LBC_MASK_ANODE;
    end
    return value;
  endfunction : mask_of

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [5:0] word_index;
  logic       addr_hit;
  logic [4:0] slot;
  logic       setup_phase;
  logic       access_done;
  logic       write_commit;

  assign word_index = paddr_in[7:2];
  assign addr_hit   = (paddr_in[1:0] == 2'h0) &&
                      (word_index >= `LBC_IDX_PULSE_A) &&
                      (word_index <= `LBC_IDX_ANODE_TIE);
  assign slot       = 5'(word_index - `LBC_IDX_PULSE_A);

  assign setup_phase  = psel_in && !penable_in;
  assign access_done  = psel_in && penable_in && pready_out;
  // Writes land only at the completing edge of the access phase.
  assign write_commit = access_done && pwrite_in && addr_hit && pstrb_in[0];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] reg_value [`LBC_REG_COUNT];

  genvar g;
  generate
    for (g = 0; g < `LBC_REG_COUNT; g++) begin : g_slot
      lbc_cfg_reg #(
        .RESET_VALUE (reset_of(g)),
        .WRITE_MASK  (mask_of(g))
      ) u_reg (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .write_in  (write_commit && (slot == 5'(g))),
        .data_in   (pwdata_in[7:0]),
        .value_out (reg_value[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // The answer is prepared in the setup cycle so that every bus
  // output comes from a flop while still costing no wait state.
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  always_comb begin
    prdata_next = 32'h0000_0000;
    if (addr_hit && !pwrite_in) begin
      prdata_next = {24'h00_0000, reg_value[slot]};
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= !addr_hit;
    end else if (access_done) begin
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_reg <= prdata_next;
    end else if (access_done) begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  assign pready_out  = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign prdata_out  = prdata_reg;

  // ----------------------------------------------------------------
  // High-voltage banks A and B
  // ----------------------------------------------------------------
  lbc_pkg::lbc_bank_cfg_t [5:0] bank_cfg_next;
  logic [7:0]                   ab_setup;

  assign ab_setup = reg_value[SLOT_AB];

  lbc_bank_decode #(
    .LOW_VOLTAGE (1'b0),
    .HV_MAP      (lbc_pkg::LBC_SRC_MAP_ONE)
  ) u_bank_a (
    .pulse_in   (reg_value[0]),
    .select_in  ({1'b0, ab_setup[`LBC_AB_A_SOURCE_BIT]}),
    .linear_in  (ab_setup[`LBC_AB_A_LINEAR_BIT]),
    .pattern_in (1'b0),
    .max_in     (reg_value[SLOT_MAX]),
    .cfg_out    (bank_cfg_next[0])
  );

  lbc_bank_decode #(
    .LOW_VOLTAGE (1'b0),
    .HV_MAP      (lbc_pkg::LBC_SRC_MAP_TWO)
  ) u_bank_b (
    .pulse_in   (reg_value[1]),
    .select_in  ({1'b0, ab_setup[`LBC_AB_B_SOURCE_BIT]}),
    .linear_in  (ab_setup[`LBC_AB_B_LINEAR_BIT]),
    .pattern_in (1'b0),
    .max_in     (reg_value[SLOT_MAX + 1]),
    .cfg_out    (bank_cfg_next[1])
  );

  // ----------------------------------------------------------------
  // Low-voltage banks C to F
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_low_bank
      logic [7:0] lv_setup;
      assign lv_setup = reg_value[SLOT_LV + g];
      lbc_bank_decode #(
        .LOW_VOLTAGE (1'b1),
        .HV_MAP      (lbc_pkg::LBC_SRC_MAP_ONE)
      ) u_bank (
        .pulse_in   (reg_value[2 + g]),
        .select_in  (lv_setup[1:0]),
        .linear_in  (lv_setup[`LBC_LV_LINEAR_BIT]),
        .pattern_in (lv_setup[`LBC_LV_PATTERN_BIT]),
        .max_in     (reg_value[SLOT_MAX + 2 + g]),
        .cfg_out    (bank_cfg_next[2 + g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // One flop stage keeps the analog side free of decode glitches;
  // the cost is one cycle between a write and its effect.
  lbc_pkg::lbc_bank_cfg_t [5:0] bank_cfg_reg;
  lbc_pkg::lbc_anode_t          anode_tie_reg;
  lbc_pkg::lbc_anode_t          anode_tie_next;
  logic [7:0]                   anode_raw;

  assign anode_raw                              = reg_value[SLOT_ANODE];
  assign anode_tie_next.high_voltage_string_tie = anode_raw[1:0];
  assign anode_tie_next.low_voltage_sink_tie    = anode_raw[6:2];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int b = 0; b < 6; b++) begin
        bank_cfg_reg[b]                     <= '0;
        bank_cfg_reg[b].pwm_zone_enable     <= 5'h1C;
        bank_cfg_reg[b].full_scale_code     <= 5'(`LBC_RST_MAX);
        bank_cfg_reg[b].full_scale_tenth_ma <= 9'h0CA;
      end
    end else begin
      bank_cfg_reg <= bank_cfg_next;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      anode_tie_reg <= 7'h7F;
    end else begin
      anode_tie_reg <= anode_tie_next;
    end
  end

  assign bank_cfg_out  = bank_cfg_reg;
  assign anode_tie_out = anode_tie_reg;

endmodule : lbc_config_bank

// ### sim/lbc_config_bank_assertions.sv
`timescale 1ns/1ps
module lbc_config_bank_checker (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [7:0]              paddr_in,
  input  wire logic [31:0]             pwdata_in,
  input  wire logic [3:0]              pstrb_in,
  input  wire logic [31:0]             prdata_out,
  input  wire logic                    pready_out,
  input  wire logic                    pslverr_out,
  input  lbc_pkg::lbc_bank_cfg_t [5:0] bank_cfg_out,
  input  lbc_pkg::lbc_anode_t          anode_tie_out
);
  // ----------------------------------------------------------------
  // Helper flags over the banks and the bus address.
  // ----------------------------------------------------------------
  logic fs_ok;
  logic pat_ok;
  logic mapped;
  assign mapped = paddr_in[1:0] == 2'h0 && paddr_in[7:2] >= 6'h14 && paddr_in[7:2] <= 6'h25;
  always_comb begin
    fs_ok = 1'b1;
    pat_ok = 1'b1;
    for (int i = 0; i < 6; i++) begin
      fs_ok &= bank_cfg_out[i].full_scale_tenth_ma == 9'h032 + 9'h008 * bank_cfg_out[i].full_scale_code;
      if (i > 1 && bank_cfg_out[i].pattern_enable && bank_cfg_out[i].zone_target_used) pat_ok = 1'b0;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_store(logic [7:0] a);
    psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0] && paddr_in == a;
  endsequence
  chk_zero_wait: assert property (s_setup |=> pready_out)
    else $error("No ready after setup.");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("Ready held too long.");
  chk_bad_addr: assert property (s_setup ##0 !mapped |=> pslverr_out && prdata_out == 32'h0)
    else $error("Unmapped access not refused.");
  chk_read_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("Upper read bits not zero.");
  chk_pulse_store: assert property (s_store(8'h50) |=> ##1
    {bank_cfg_out[0].pwm_zone_enable, bank_cfg_out[0].pwm_enable} == $past(pwdata_in[5:0], 2))
    else $error("Pulse setup not applied.");
  chk_max_store: assert property (s_store(8'h7C) |=> ##1
    bank_cfg_out[0].full_scale_code == $past(pwdata_in[4:0], 2))
    else $error("Full-scale code not applied.");
  chk_anode_store: assert property (s_store(8'h94) |=> ##1 anode_tie_out == $past(pwdata_in[6:0], 2))
    else $error("Anode ties not applied.");
  chk_fs_formula: assert property (fs_ok)
    else $error("Full-scale current wrong.");
  chk_pattern_ignore: assert property (pat_ok)
    else $error("Zone targets used with pattern on.");
  chk_ab_sources: assert property (!bank_cfg_out[0].source[1] && !bank_cfg_out[1].source[0])
    else $error("Bank A or B source out of range.");
endmodule : lbc_config_bank_checker

bind lbc_config_bank lbc_config_bank_checker u_chk (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .bank_cfg_out, .anode_tie_out);

// ### sim/lbc_config_bank_tb_top.sv
`timescale 1ns/1ps
module lbc_config_bank_tb_top;
  logic                         clk_in;
  logic                         reset_in;
  logic                         psel_in;
  logic                         penable_in;
  logic                         pwrite_in;
  logic [7:0]                   paddr_in;
  logic [31:0]                  pwdata_in;
  logic [3:0]                   pstrb_in;
  logic [31:0]                  prdata_out;
  logic                         pready_out;
  logic                         pslverr_out;
  lbc_pkg::lbc_bank_cfg_t [5:0] bank_cfg_out;
  lbc_pkg::lbc_anode_t          anode_tie_out;
  logic [33:0]                  exp_q[$];
  logic [7:0]                   rv[6'h14:6'h25];
  logic [7:0]                   d;
  int                           fails;
  int                           n_checks;
  int                           cycles;
  integer                       seed;

  lbc_config_bank dut (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .bank_cfg_out, .anode_tie_out);

  // ----------------------------------------------------------------
  // Bus master, shadow registers and checks.
  // ----------------------------------------------------------------
  function automatic logic [15:0] reg_info(input logic [5:0] i);
    if (i < 6'h1A) return 16'h383F;
    if (i < 6'h1F) return 16'h000F;
    if (i < 6'h25) return 16'h131F;
    return 16'h7F7F;
  endfunction : reg_info

  task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] v, input logic [3:0] s);
    logic ok;
    ok = a[1:0] == 2'h0 && a[7:2] >= 6'h14 && a[7:2] <= 6'h25;
    if (wr && ok && s[0]) rv[a[7:2]] = v & reg_info(a[7:2]);
    exp_q.push_back({!wr, !ok, 24'h0, ok ? rv[a[7:2]] : 8'h00});
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= {$random(seed)} << 8 | v;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : xfer

  task automatic cmp_bus(input logic [33:0] e);
    n_checks++;
    if (pslverr_out !== e[32] || (e[33] && prdata_out !== e[31:0])) begin
      fails++;
      $display("mismatch at %0t: bus answer %h %b, expected %h", $time, prdata_out, pslverr_out, e[32:0]);
    end
  endtask : cmp_bus

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask : cmp_out

  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // The watcher samples at the completing edge, the same edge the master uses.
  always @(posedge clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1) cmp_bus(exp_q.pop_front());
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    seed = 32'hD64A4495;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = '0;
    reset_in = 1'b1;
    for (int i = 'h14; i <= 'h25; i++) rv[i] = reg_info(6'(i)) >> 8;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int k = 0; k < 6; k++) cmp_out(32'(bank_cfg_out[k]), 32'h00E0_26CA);
    cmp_out(32'(anode_tie_out), 32'h7F);
    for (int p = 0; p < 3; p++) begin
      for (int i = 'h14; i <= 'h25; i++) if (p > 0) xfer({i[5:0], 2'h0}, 1'b1, p == 1 ? 8'hFF : 8'($random(seed)), 4'hF);
      for (int i = 'h14; i <= 'h25; i++) xfer({i[5:0], 2'h0}, 1'b0, 8'h00, 4'hF);
    end
    for (int j = 0; j < 8; j++) xfer(j[0] ? 8'h4C : 8'h51 + 8'(j * 10), j[1], 8'hFF, 4'hF);
    xfer(8'h7C, 1'b1, 8'h05, 4'hE);
    xfer(8'h7C, 1'b0, 8'h00, 4'hF);
    for (int v = 0; v < 16; v++) begin
      d = 8'(v);
      xfer(8'h68, 1'b1, d, 4'hF);
      cmp_out(bank_cfg_out[0][18:14], {1'b0, d[0], d[0], d[1], 1'b0});
      cmp_out(bank_cfg_out[1][18:14], {d[2], 1'b0, d[2], d[3], 1'b0});
      for (int k = 2; k < 6; k++) begin
        xfer(8'h64 + 8'(k * 4), 1'b1, d, 4'hF);
        cmp_out(bank_cfg_out[k][18:14], {d[1], d[1] & d[0], d[1] & !d[3], d[2], d[3]});
      end
    end
    for (int n = 0; n < 6; n++) begin
      for (int k = 0; k < 6; k++) begin
        d = n == 0 ? 8'h00 : n == 1 ? 8'hFF : 8'($random(seed));
        xfer(8'h50 + 8'(k * 4), 1'b1, d, 4'hF);
        xfer(8'h7C + 8'(k * 4), 1'b1, d ^ 8'h0A, 4'hF);
        cmp_out(bank_cfg_out[k][24:19], {d[0], d[5:1]});
        cmp_out(bank_cfg_out[k][13:0], {d[4:0] ^ 5'h0A, 9'h032 + 9'h008 * (d[4:0] ^ 5'h0A)});
      end
      xfer(8'h94, 1'b1, d, 4'hF);
      cmp_out(32'(anode_tie_out), d[6:0]);
    end
    give_verdict();
  end
endmodule : lbc_config_bank_tb_top
